// ===== rcs_consts.svh
// constants for the remote command and status stream block
// Behaviour
// - each measurement averages 2^i samples, exponent i accepted from 0 to 8
// - writing the exponent clears average memory; host waits 30 ms to refill
// - stream command 1 starts endless packet emission, 0 stops it
// - poll query sends exactly one packet
// - protocol version query returns 2
// - words go out least significant bit first; host stores each bit at its own index, no byte reversal
// - fast-state bit 2 toggles on each line zero crossing
// - fast-state bit 3 is high while compliance limiting
// - bit 11 shows ramp running, bit 12 toggles on ramp start or repeat
// - bits 15 to 18 carry the averaging exponent
// - bit 19 pulse running, bit 20 toggles per edge, bit 21 per start
// - bit 22 arbitrary running, bit 23 toggles per start or repeat
// - overload byte bit 2 voltage, bit 3 current, during the previous packet
// - operation-complete query always answers 1
// - operation-complete command sets the event status complete bit
// - common reset returns every setting to default
// - terse mode suppresses unsolicited output, verbose emits it
// - lockout ignores keys except local, which clears lockout
// - a query before the last reply is read flags error and is itself ignored
// - interface clear empties queues, leaves unread-query bit set
// - display command picks line 0 or 1, string under 24 chars, upper case
// - timebase query gives 0 internal, 1 external, 2 external disabled
`ifndef RCS_CONSTS_SVH
`define RCS_CONSTS_SVH
`define RCS_A_CMD      4'h0
`define RCS_A_ARG      4'h1
`define RCS_A_REPLY    4'h2
`define RCS_A_STATUS   4'h3
`define RCS_A_ISTAT    4'h4
`define RCS_A_FAST     4'h5
`define RCS_A_CTRL     4'h6
`define RCS_A_ESR      4'h7
`define RCS_AVG_MAX    4'h8
`define RCS_PROTO      32'h0000_0002
`define RCS_DISP_MAX   8'h18
`define RCS_BIT_REF    15
`define RCS_REFILL_MS  30
`define RCS_CLK_KHZ    25000
`define RCS_REFILL_CYC (`RCS_REFILL_MS * `RCS_CLK_KHZ)
`endif

// ===== rcs_pkg.sv
// types of the remote command and status stream block
package rcs_pkg;
	typedef enum logic [3:0] {
		RCS_NOP    = 4'h0,
		RCS_AVG    = 4'h1,
		RCS_STREAM = 4'h2,
		RCS_POLL   = 4'h3,
		RCS_PROTOQ = 4'h4,
		RCS_OPCQ   = 4'h5,
		RCS_OPC    = 4'h6,
		RCS_RST    = 4'h7,
		RCS_VERB   = 4'h8,
		RCS_LOCK   = 4'h9,
		RCS_IFC    = 4'ha,
		RCS_DISP   = 4'hb,
		RCS_NULQ   = 4'hc,
		RCS_TBQ    = 4'hd,
		RCS_AUTOTB = 4'he,
		RCS_AVGQ   = 4'hf
	} rcs_cmd_e;
	typedef enum logic [1:0] {
		RCS_IDLE = 2'b00,
		RCS_SEND = 2'b01
	} rcs_tx_e;
	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
		logic [31:0] arg;
		logic [3:0]  avg_exp;
		logic        avg_clear;
		logic [29:0] refill;
		logic        stream_on;
		logic        poll_req;
		rcs_tx_e     tx;
		logic [31:0] sh;
		logic [5:0]  bitcnt;
		logic        word_sel;
		logic        tx_bit;
		logic        tx_valid;
		logic        verbose;
		logic        locked;
		logic        auto_tb;
		logic        reply_full;
		logic [31:0] reply;
		logic [15:0] instrument_status_register;
		logic [7:0]  esr;
		logic        line_tog;
		logic        ramp_tog;
		logic        pedge_tog;
		logic        pstart_tog;
		logic        arb_tog;
		logic        eovl;
		logic        iovl;
		logic [7:0]  ovl_pkt;
		logic        key_out;
		logic        disp_we;
		logic        disp_line;
		logic [7:0]  disp_ch;
		logic        err_out;
	} rcs_state_s;
endpackage

// ===== rcs_stream.sv
// command handler, status word packing and lsb-first binary stream
`timescale 1ns/100ps
`include "rcs_consts.svh"
module rcs_stream #(
	parameter int REFILL_CYC = `RCS_REFILL_CYC
) (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	// wishbone slave
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [3:0]  i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack,
	// instrument event pins
	input  wire logic        i_zero_cross,
	input  wire logic        i_limiting,
	input  wire logic        i_ramp_run,
	input  wire logic        i_ramp_start,
	input  wire logic        i_pulse_run,
	input  wire logic        i_pulse_edge,
	input  wire logic        i_pulse_start,
	input  wire logic        i_arb_run,
	input  wire logic        i_arb_start,
	input  wire logic        i_e_ovl,
	input  wire logic        i_i_ovl,
	input  wire logic        i_ext_tb,
	input  wire logic        i_key,
	input  wire logic        i_key_local,
	input  wire logic        i_error,
	// outputs
	output logic             o_tx_bit,
	output logic             o_tx_valid,
	output logic             o_avg_clear,
	output logic [3:0]       o_avg_exp,
	output logic             o_key,
	output logic             o_err_msg,
	output logic             o_disp_we,
	output logic             o_disp_line,
	output logic [7:0]       o_disp_ch
);
	import rcs_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers, three flops each; edge detect compares stages two and three
	localparam int NP = 15;
	logic [NP-1:0] s1, s2, s3;
	wire  [NP-1:0] pins = {i_error, i_key_local, i_key, i_ext_tb, i_i_ovl, i_e_ovl,
		i_arb_start, i_arb_run, i_pulse_start, i_pulse_edge, i_pulse_run,
		i_ramp_start, i_ramp_run, i_limiting, i_zero_cross};
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else begin
			s1 <= pins;
			s2 <= s1;
			s3 <= s2;
		end
	end
	wire [NP-1:0] rise = s2 & ~s3;

	// upper-case a character; display hardware only sees capitals
	function automatic logic [7:0] upcase(input logic [7:0] c);
		upcase = (c >= 8'h61 && c <= 8'h7a) ? c - 8'h20 : c;
	endfunction

	////////////////////////////////////////////////////////////////////////
	rcs_state_s r, n;
	logic [31:0] fast;
	logic [31:0] frame0;
	logic        acc, wr, rd;

	// fast-state word, unused and internal bits held at zero
	always_comb begin
		fast = 32'h0000_0000;
		fast[2] = r.line_tog;
		fast[3] = s2[1];
		fast[11] = s2[2];
		fast[12] = r.ramp_tog;
		fast[18:15] = r.avg_exp;
		fast[19] = s2[4];
		fast[20] = r.pedge_tog;
		fast[21] = r.pstart_tog;
		fast[22] = s2[7];
		fast[23] = r.arb_tog;
	end
	assign frame0 = fast;
	assign acc = i_wb_cyc && i_wb_stb && !r.ack;
	assign wr  = acc && i_wb_we && i_wb_sel[0];
	assign rd  = acc && !i_wb_we;

	// next-state logic: bus, commands, events and serialiser
	always_comb begin
		n = r;
		n.ack = acc;
		n.avg_clear = 1'b0;
		n.key_out = 1'b0;
		n.disp_we = 1'b0;
		n.err_out = 1'b0;
		n.tx_valid = 1'b0;
		if (r.refill != '0)
			n.refill = r.refill - 30'h1;
		// toggles from instrument events
		if (rise[0]) n.line_tog = ~r.line_tog;
		if (rise[3]) n.ramp_tog = ~r.ramp_tog;
		if (rise[5]) n.pedge_tog = ~r.pedge_tog;
		if (rise[6]) n.pstart_tog = ~r.pstart_tog;
		if (rise[8]) n.arb_tog = ~r.arb_tog;
		if (s2[9]) n.eovl = 1'b1;
		if (s2[10]) n.iovl = 1'b1;
		// front panel keys gated by lockout; local key always passes
		if (rise[13]) begin
			n.locked = 1'b0;
			n.key_out = 1'b1;
		end else if (rise[12] && !r.locked) begin
			n.key_out = 1'b1;
		end
		if (rise[14] && r.verbose) n.err_out = 1'b1;
		// reads
		if (rd) begin
			unique case (i_wb_adr)
				`RCS_A_REPLY: begin
					n.dat = r.reply;
					n.reply_full = 1'b0;
				end
				`RCS_A_STATUS: n.dat = {22'h0, r.tx, s2[11], r.auto_tb, r.locked,
					r.verbose, r.stream_on, r.reply_full, r.refill != '0, 1'b0};
				`RCS_A_ISTAT: begin
					n.dat = {16'h0, r.instrument_status_register};
					n.instrument_status_register = 16'h0;
				end
				`RCS_A_FAST: n.dat = fast;
				`RCS_A_CTRL: n.dat = {28'h0, r.avg_exp};
				`RCS_A_ESR: begin
					n.dat = {24'h0, r.esr};
					n.esr = 8'h0;
				end
				`RCS_A_ARG: n.dat = r.arg;
				default: n.dat = 32'h0;
			endcase
		end
		// writes; a command is executed when written to the command word
		if (wr && i_wb_adr == `RCS_A_ARG) n.arg = i_wb_dat;
		if (wr && i_wb_adr == `RCS_A_CMD) begin
			// a query while a reply waits unread is refused
			if (r.reply_full && i_wb_dat[4] && i_wb_dat[3:0] != RCS_IFC) begin
				n.instrument_status_register[`RCS_BIT_REF] = 1'b1;
				n.esr[2] = 1'b1;
			end else begin
				if (i_wb_dat[4]) n.reply_full = 1'b1;
				unique case (rcs_cmd_e'(i_wb_dat[3:0]))
					RCS_NOP: ;
					RCS_AVG: if (r.arg[31:4] == '0 && r.arg[3:0] <= `RCS_AVG_MAX) begin
						n.avg_exp = r.arg[3:0];
						n.avg_clear = 1'b1;
						n.refill = 30'(REFILL_CYC);
					end else begin
						n.esr[4] = 1'b1;
						n.err_out = r.verbose;
					end
					RCS_STREAM: n.stream_on = r.arg[0];
					RCS_POLL: n.poll_req = 1'b1;
					RCS_PROTOQ: n.reply = `RCS_PROTO;
					RCS_OPCQ: n.reply = 32'h1;
					RCS_OPC: n.esr[0] = 1'b1;
					RCS_RST: begin
						n.avg_exp = 4'h0;
						n.stream_on = 1'b0;
						n.verbose = 1'b0;
						n.locked = 1'b0;
						n.auto_tb = 1'b1;
						n.avg_clear = 1'b1;
					end
					RCS_VERB: n.verbose = r.arg[0];
					RCS_LOCK: n.locked = r.arg[0];
					RCS_IFC: begin
						n.reply_full = 1'b0;
						n.poll_req = 1'b0;
					end
					RCS_DISP: if (r.arg[15:8] < `RCS_DISP_MAX && r.arg[7:0] > 8'h20) begin
						n.disp_we = 1'b1;
						n.disp_line = r.arg[16];
						n.disp_ch = upcase(r.arg[7:0]);
					end
					RCS_NULQ: n.reply = 32'h0;
					RCS_TBQ: n.reply = !s2[11] ? 32'h0 :
						(r.auto_tb ? 32'h1 : 32'h2);
					RCS_AUTOTB: n.auto_tb = r.arg[0];
					RCS_AVGQ: n.reply = {28'h0, r.avg_exp};
				endcase
			end
		end
		// serialiser: state word then overload byte, lsb first
		unique case (r.tx)
			RCS_IDLE: if (r.stream_on || r.poll_req) begin
				n.poll_req = 1'b0;
				n.sh = frame0;
				n.bitcnt = 6'd31;
				n.word_sel = 1'b0;
				n.ovl_pkt = {4'h0, r.iovl, r.eovl, 2'b00};
				n.eovl = s2[9];
				n.iovl = s2[10];
				n.tx = RCS_SEND;
			end
			RCS_SEND: begin
				n.tx_bit = r.sh[0];
				n.tx_valid = 1'b1;
				n.sh = {1'b0, r.sh[31:1]};
				if (r.bitcnt != 6'd0) begin
					n.bitcnt = r.bitcnt - 6'd1;
				end else if (!r.word_sel) begin
					n.word_sel = 1'b1;
					n.sh = {24'h0, r.ovl_pkt};
					n.bitcnt = 6'd7;
				end else begin
					n.tx = RCS_IDLE;
				end
			end
			default: n.tx = RCS_IDLE;
		endcase
	end

	// single register of all state but the pin synchronisers
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r <= '0;
			r.auto_tb <= 1'b1;
			r.esr <= 8'h80;
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from flops
	assign o_wb_dat = r.dat;
	assign o_wb_ack = r.ack;
	assign o_tx_bit = r.tx_bit;
	assign o_tx_valid = r.tx_valid;
	assign o_avg_clear = r.avg_clear;
	assign o_avg_exp = r.avg_exp;
	assign o_key = r.key_out;
	assign o_err_msg = r.err_out;
	assign o_disp_we = r.disp_we;
	assign o_disp_line = r.disp_line;
	assign o_disp_ch = r.disp_ch;

	////////////////////////////////////////////////////////////////////////
	a_avg_range: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		r.avg_exp <= 4'h8) else $error("average exponent out of range");
	a_avg_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_avg_clear |-> r.refill != '0 || $past(rcs_cmd_e'(i_wb_dat[3:0])) == RCS_RST)
		else $error("clear without refill wait");
	a_stream_go: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		r.stream_on && r.tx == RCS_IDLE |=> r.tx == RCS_SEND)
		else $error("stream did not start a packet");
	a_lsb_first: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		r.tx == RCS_SEND && !r.word_sel |=> o_tx_bit == $past(r.sh[0]))
		else $error("bit order wrong");
	a_fast_resv: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		fast[1] == 1'b0 && fast[14:13] == 2'b00 && fast[31:24] == 8'h00)
		else $error("reserved state bits set");
	a_avg_field: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		fast[18:15] == o_avg_exp) else $error("average field mismatch");
	a_lock_local: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		rise[13] |=> !r.locked) else $error("local key did not unlock");
	a_key_block: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		r.locked && rise[12] && !rise[13] |=> !o_key) else $error("locked key passed");
	a_terse_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!$past(r.verbose) |-> !o_err_msg) else $error("terse mode spoke");
	a_ref_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		wr && i_wb_adr == `RCS_A_CMD && r.reply_full && i_wb_dat[4]
		&& i_wb_dat[3:0] != 4'ha |=> r.instrument_status_register[15]) else $error("refused query not flagged");
	c_stream: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		r.tx == RCS_SEND && r.word_sel && r.bitcnt == 6'd0);
	c_refuse: cover property (@(posedge i_clk) disable iff (!i_rst_n) r.instrument_status_register[15]);
	c_disp: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_disp_we);
	c_poll: cover property (@(posedge i_clk) disable iff (!i_rst_n) r.poll_req);
	c_refill: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_avg_clear);

	////////////////////////////////////////////////////////////////////////
	// command words that the handler accepts; a refused query only sets its error flags
	wire       cmd_wr = wr && i_wb_adr == `RCS_A_CMD;
	wire       cmd_ok = cmd_wr && !(r.reply_full && i_wb_dat[4] && i_wb_dat[3:0] != 4'ha);
	wire [3:0] cmd_code = i_wb_dat[3:0];
	a_proto_val: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		cmd_ok && cmd_code == 4'h4 |=> r.reply == 32'h2)
		else $error("protocol reply wrong");
	a_opc_one: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		cmd_ok && cmd_code == 4'h5 |=> r.reply == 32'h1)
		else $error("complete query reply wrong");
	a_opc_bit: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		cmd_ok && cmd_code == 4'h6 |=> r.esr[0])
		else $error("complete bit not set");
	a_null_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		cmd_ok && cmd_code == 4'hc |=> r.reply == 32'h0)
		else $error("null reply wrong");
	a_tb_code: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		cmd_ok && cmd_code == 4'hd |=> r.reply <= 32'h2)
		else $error("timebase code out of range");
	a_ifc_keep: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		cmd_ok && cmd_code == 4'ha && r.instrument_status_register[15] |=> r.instrument_status_register[15] && !r.reply_full)
		else $error("interface clear wrong");
	a_rst_dflt: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		cmd_ok && cmd_code == 4'h7 |=> r.avg_exp == 4'h0 && !r.stream_on && !r.verbose)
		else $error("reset left a setting");
	a_ovl_resv: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		r.ovl_pkt[1:0] == 2'b00 && r.ovl_pkt[7:4] == 4'h0)
		else $error("reserved overload bits set");
	a_disp_upper: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_disp_we |-> !(o_disp_ch >= 8'h61 && o_disp_ch <= 8'h7a))
		else $error("display char not upper case");
	a_poll_once: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		r.poll_req && r.tx == RCS_IDLE |=> !r.poll_req)
		else $error("poll request not consumed");
endmodule // rcs_stream

// ===== rcs_host_rx.sv
// host-side receiver that rebuilds streamed status packets
`timescale 1ns/100ps
module rcs_host_rx (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	// serial stream from the device
	input  wire logic        i_tx_bit,
	input  wire logic        i_tx_valid,
	// rebuilt packet
	output logic      [31:0] o_fast,
	output logic      [7:0]  o_ovl,
	output int               o_pkts
);
	logic [5:0] idx;
	////////////////////////////////////////////////////////////////////////
	// first bit on the wire is bit 0 of the word; the byte comes after it
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			idx <= 6'h00;
			o_fast <= 32'h0;
			o_ovl <= 8'h00;
			o_pkts <= 0;
		end else if (i_tx_valid) begin
			if (idx < 6'h20) begin
				o_fast[idx[4:0]] <= i_tx_bit;
			end else begin
				o_ovl[idx[2:0]] <= i_tx_bit;
			end
			// a packet counts only once its last bit is in
			if (idx == 6'h27) begin
				idx <= 6'h00;
				o_pkts <= o_pkts + 1;
			end else begin
				idx <= idx + 6'h01;
			end
		end
	end
endmodule // rcs_host_rx

// ===== tb_top.sv
// self-checking bench for the command handler and its packet stream
`timescale 1ns/100ps
`include "rcs_consts.svh"
module tb_top;
	import rcs_pkg::*;
	logic        i_clk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [14:0] ev = 15'h0;
	logic [31:0] rdat, f0, o_wb_dat, fast;
	logic        ack, tx_bit, tx_valid, avg_clr, okey, emsg, dwe, dln, last_ln;
	logic [3:0]  avg_exp;
	logic [7:0]  dch, last_ch, ovl;
	int          failures, check_count, cycles, keys, errs, clears, pkts, p;
	int          pos[9] = '{2, 3, 11, 12, 19, 20, 21, 22, 23};
	////////////////////////////////////////////////////////////////////////
	// short refill count keeps the run brief
	rcs_stream #(.REFILL_CYC(16)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
		.i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(o_wb_dat), .o_wb_ack(ack),
		.i_zero_cross(ev[0]), .i_limiting(ev[1]), .i_ramp_run(ev[2]),
		.i_ramp_start(ev[3]), .i_pulse_run(ev[4]), .i_pulse_edge(ev[5]),
		.i_pulse_start(ev[6]), .i_arb_run(ev[7]), .i_arb_start(ev[8]),
		.i_e_ovl(ev[9]), .i_i_ovl(ev[10]), .i_ext_tb(ev[11]), .i_key(ev[12]),
		.i_key_local(ev[13]), .i_error(ev[14]), .o_tx_bit(tx_bit),
		.o_tx_valid(tx_valid), .o_avg_clear(avg_clr), .o_avg_exp(avg_exp),
		.o_key(okey), .o_err_msg(emsg), .o_disp_we(dwe), .o_disp_line(dln),
		.o_disp_ch(dch));
	rcs_host_rx host (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_tx_bit(tx_bit),
		.i_tx_valid(tx_valid), .o_fast(fast), .o_ovl(ovl), .o_pkts(pkts));
	always #20 i_clk = ~i_clk;
	////////////////////////////////////////////////////////////////////////
	// count output pulses; the cycle ceiling cuts a hang short
	always @(posedge i_clk) begin
		cycles++;
		if (okey === 1'b1) keys++;
		if (emsg === 1'b1) errs++;
		if (avg_clr === 1'b1) clears++;
		if (dwe === 1'b1) begin
			last_ch = dch;
			last_ln = dln;
		end
		if (cycles > 30000) begin
			failures++;
			conclude;
		end
	end
	task conclude;
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	// one classic cycle; request held until ack is sampled high
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge i_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) begin
			failures++;
			$display("BAD ack expected 1 seen %b", ack);
		end
		rdat = o_wb_dat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task cmd(input rcs_cmd_e c, input logic [31:0] a, input logic q);
		wb(1'b1, `RCS_A_ARG, a);
		wb(1'b1, `RCS_A_CMD, {27'h0, q, c});
	endtask
	task ask(input rcs_cmd_e c, input logic [31:0] a, input logic [31:0] e);
		cmd(c, a, 1'b1);
		wb(1'b0, `RCS_A_REPLY, 32'h0);
		chk("reply", rdat, e);
	endtask
	task rd(input logic [3:0] a);
		wb(1'b0, a, 32'h0);
	endtask
	// inputs pass a synchroniser, so hold each event several cycles
	task hit(input int k);
		ev[k] <= 1'b1;
		tick(5);
		ev[k] <= 1'b0;
		tick(5);
	endtask
	task poll(input logic [7:0] ov);
		p = pkts;
		cmd(RCS_POLL, 32'h0, 1'b0);
		tick(120);
		chk("pkts", pkts, p + 1);
		chk("ovl", ovl, ov);
		chk("pfast", fast[18:15], 4'h8);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		tick(12);
		i_rst_n <= 1'b1;
		rd(`RCS_A_FAST);
		chk("rsvd", rdat & 32'hff006002, 32'h0);
		wb(1'b1, 4'ha, 32'h5);
		rd(4'ha);
		chk("unmapped", rdat, 32'h0);
		ask(RCS_PROTOQ, 32'h0, 32'h2);
		ask(RCS_OPCQ, 32'h0, 32'h1);
		ask(RCS_NULQ, 32'h0, 32'h0);
		ask(RCS_TBQ, 32'h0, 32'h0);
		ev[11] <= 1'b1;
		tick(5);
		ask(RCS_TBQ, 32'h0, 32'h1);
		cmd(RCS_AUTOTB, 32'h0, 1'b0);
		ask(RCS_TBQ, 32'h0, 32'h2);
		cmd(RCS_AUTOTB, 32'h1, 1'b0);
		ev[11] <= 1'b0;
		// averaging exponent and refill window
		p = clears;
		cmd(RCS_AVG, 32'h4, 1'b0);
		rd(`RCS_A_STATUS);
		chk("refill", rdat[1], 32'h1);
		chk("clears", clears, p + 1);
		tick(30);
		rd(`RCS_A_STATUS);
		chk("refilled", rdat[1], 32'h0);
		ask(RCS_AVGQ, 32'h0, 32'h4);
		rd(`RCS_A_FAST);
		chk("fexp", rdat[18:15], 32'h4);
		cmd(RCS_AVG, 32'h9, 1'b0);
		rd(`RCS_A_CTRL);
		chk("badexp", rdat, 32'h4);
		rd(`RCS_A_ESR);
		chk("exe", rdat[4], 32'h1);
		cmd(RCS_AVG, 32'h8, 1'b0);
		rd(`RCS_A_CTRL);
		chk("maxexp", rdat, 32'h8);
		chk("oexp", avg_exp, 32'h8);
		// each state input, level bits follow and toggle bits flip once
		for (int k = 0; k < 9; k++) begin
			rd(`RCS_A_FAST);
			f0 = rdat;
			ev[k] <= 1'b1;
			tick(5);
			rd(`RCS_A_FAST);
			chk("fhigh", rdat, f0 ^ (32'h1 << pos[k]));
			ev[k] <= 1'b0;
			tick(5);
			rd(`RCS_A_FAST);
			chk("flow", rdat, f0 ^ ((32'h1 << pos[k]) & 32'h00b01004));
		end
		poll(8'h00);
		hit(9);
		poll(8'h04);
		hit(10);
		poll(8'h08);
		poll(8'h00);
		// continuous stream, then stop and see it stay quiet
		p = pkts;
		cmd(RCS_STREAM, 32'h1, 1'b0);
		tick(300);
		cmd(RCS_STREAM, 32'h0, 1'b0);
		tick(60);
		f0 = pkts;
		tick(100);
		chk("stop", pkts, f0);
		chk("run", (pkts - p) >= 6, 32'h1);
		p = errs;
		cmd(RCS_VERB, 32'h1, 1'b0);
		hit(14);
		cmd(RCS_VERB, 32'h0, 1'b0);
		hit(14);
		chk("errs", errs, p + 1);
		p = keys;
		cmd(RCS_LOCK, 32'h1, 1'b0);
		hit(12);
		chk("locked", keys, p);
		hit(13);
		p = keys;
		hit(12);
		chk("unlocked", keys, p + 1);
		cmd(RCS_DISP, {15'h0, 1'b1, 8'h03, 8'h61}, 1'b0);
		tick(5);
		chk("disp", {last_ln, last_ch}, 32'h141);
		// second query before the reply is read is refused
		cmd(RCS_PROTOQ, 32'h0, 1'b1);
		cmd(RCS_NULQ, 32'h0, 1'b1);
		rd(`RCS_A_ESR);
		chk("qye", rdat[2], 32'h1);
		cmd(RCS_IFC, 32'h0, 1'b0);
		rd(`RCS_A_ISTAT);
		chk("refbit", rdat[15], 32'h1);
		rd(`RCS_A_ISTAT);
		chk("refclr", rdat[15], 32'h0);
		ask(RCS_NULQ, 32'h0, 32'h0);
		cmd(RCS_OPC, 32'h0, 1'b0);
		rd(`RCS_A_ESR);
		chk("opc", rdat[0], 32'h1);
		cmd(RCS_LOCK, 32'h1, 1'b0);
		cmd(RCS_RST, 32'h0, 1'b0);
		rd(`RCS_A_CTRL);
		chk("rstexp", rdat, 32'h0);
		p = keys;
		hit(12);
		chk("rstlock", keys, p + 1);
		conclude;
	end
endmodule // tb_top
